/* File: inc/cwg_pkg.sv */
// shared constants and types of the complementary dead-band generator
package cwg_pkg;

  // ==========================================================
  // register byte offsets (Avalon-MM, one word each)
  localparam logic [4:0] OFS_CTRL  = 5'h00;
  localparam logic [4:0] OFS_POL   = 5'h04;
  localparam logic [4:0] OFS_CLK   = 5'h08;
  localparam logic [4:0] OFS_RISE  = 5'h0c;
  localparam logic [4:0] OFS_FALL  = 5'h10;
  localparam logic [4:0] OFS_SHUT  = 5'h14;
  localparam logic [4:0] OFS_SRCEN = 5'h18;
  localparam logic [4:0] OFS_STATE = 5'h1c;

  // ==========================================================
  // field positions
  localparam int CTRL_EN_BIT   = 7;
  localparam int CTRL_LD_BIT   = 6;
  localparam int POL_IN_BIT    = 5;
  localparam int CLK_SEL_BIT   = 0;
  localparam int SHUT_SD_BIT   = 7;
  localparam int SHUT_REN_BIT  = 6;
  localparam int SHUT_LBD_LSB  = 4;
  localparam int SHUT_LAC_LSB  = 2;
  localparam int STATE_RUN_BIT = 0;
  localparam int STATE_REV_BIT = 1;

  // ==========================================================
  // widths and reset values
  localparam int         DB_WIDTH  = 6;
  localparam int         SRC_COUNT = 4;
  localparam logic [2:0] MODE_RST  = 3'h0;
  localparam logic [3:0] POL_RST   = 4'h0;
  localparam logic [1:0] LVL_RST   = 2'h0;

  // ==========================================================
  // operating modes
  localparam logic [2:0] MODE_HALF = 3'h4;
  localparam logic [2:0] MODE_FWD  = 3'h2;
  localparam logic [2:0] MODE_REV  = 3'h3;

  // override level codes
  localparam logic [1:0] LVL_HIGH  = 2'h3;
  localparam logic [1:0] LVL_LOW   = 2'h2;
  localparam logic [1:0] LVL_FLOAT = 2'h1;
  localparam logic [1:0] LVL_INACT = 2'h0;

  // ==========================================================
  // types
  typedef enum logic [1:0] {ST_OFF, ST_SHUT, ST_RUN} gen_state_e;

  typedef struct packed {
    logic d;
    logic c;
    logic b;
    logic a;
  } gen_out_s;

endpackage

/* File: rtl/complementary_generator.sv */
// dead-band timing and auto-shutdown core of the complementary generator
// Functional notes
// - half bridge: out_a on delayed by rise band
// - full bridge fwd-to-rev delays only out_b
// - rise band spans 0 to 63 clocks
// - half bridge: out_b on delayed by fall band
// - full bridge rev-to-fwd delays only out_d
// - fall band spans 0 to 63 clocks
// - band starts on input edge; zero means none
// - input reverses early: waiting output stays off
// - band settings double-buffered, load on rise after fall
// - async input gives at most one clock jitter
// - software setting shutdown forces shutdown
// - no auto restart: stay shut while bit set
// - auto restart clears bit, resumes on rise
// - enabled active-low inputs force override levels
// - inputs level sensitive; hold shutdown while active
// - one field sets b/d, other sets a/c
// - shutdown setting raises generator interrupt flag
// - restart blocked while any enabled source active
// - software clear ignored while condition remains
// - with auto restart, hardware clears bit once conditions gone
// - keep fast oscillator on during sleep while enabled, clk_sel_ff set and src_active high
// - enabling starts generator in shutdown
// - band timed counting clocks up to setting
// - two 6-bit band counters, rise and fall
// - b/d override: 11 high, 10 low, 01 float
`timescale 1ns/100ps

module complementary_generator
  import cwg_pkg::*;
#(
  parameter int DB_W  = DB_WIDTH,
  parameter int NSRC  = SRC_COUNT
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [4:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic             data_in,
  input  wire logic [NSRC-1:0]  shutdown_src_n,
  input  wire logic             src_active,
  input  wire logic             sleep_mode,
  output gen_out_s              out_lvl,
  output gen_out_s              out_oe,
  output logic                  generator_irq_flag,
  output logic                  osc_keep_on
);

  // ==========================================================
  // functions

  // band counter: counts up from zero while the band runs
  function automatic logic [DB_W-1:0] band_next(
    input logic [DB_W-1:0] cnt,
    input logic            run,
    input logic [DB_W-1:0] lim
  );
    if (!run) begin
      band_next = '0;
    end else if (cnt != lim) begin
      band_next = cnt + 1'b1;
    end else begin
      band_next = cnt;
    end
  endfunction

  // override decode: returns {oe, level}
  function automatic logic [1:0] ovr_decode(
    input logic [1:0] code,
    input logic       pol
  );
    case (code)
      LVL_HIGH:  ovr_decode = 2'b11;
      LVL_LOW:   ovr_decode = 2'b10;
      LVL_FLOAT: ovr_decode = 2'b00;
      default:   ovr_decode = {1'b1, pol};
    endcase
  endfunction

  // ==========================================================
  // declarations
  localparam int SYNC_W = NSRC + 2;
  localparam logic [SYNC_W-1:0] SYNC_RST = {{NSRC{1'b1}}, 2'b00};

  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic              data_s;
  logic              active_s;
  logic [NSRC-1:0]   src_n_s;
  logic              data_d_ff;
  logic              data_rise;
  logic              data_fall;

  logic              ack_ff;
  logic              wr_fire;
  logic              bus_req;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;
  logic              wr_ok;

  logic              en_ff;
  logic              en_d_ff;
  logic              ld_req_ff;
  logic              ld_fell_ff;
  logic [2:0]        mode_ff;
  logic [3:0]        pol_ff;
  logic              clk_sel_ff;
  logic [DB_W-1:0]   rise_buf_ff;
  logic [DB_W-1:0]   fall_buf_ff;
  logic [DB_W-1:0]   rise_act_ff;
  logic [DB_W-1:0]   fall_act_ff;
  logic              sd_ff;
  logic              nxt_sd;
  logic              ren_ff;
  logic [1:0]        lvl_bd_ff;
  logic [1:0]        lvl_ac_ff;
  logic [NSRC-1:0]   src_en_ff;
  logic              hw_sd;

  gen_state_e        state_ff;
  logic              dir_ff;
  logic              pend_ff;
  logic [DB_W-1:0]   rise_cnt_ff;
  logic [DB_W-1:0]   fall_cnt_ff;
  logic              is_half;
  logic              is_full;
  logic              rise_run;
  logic              fall_run;
  logic              rise_done;
  logic              fall_done;
  logic [3:0]        act;
  logic [3:0]        nxt_lvl;
  logic [3:0]        nxt_oe;
  logic [3:0]        lvl_ff;
  logic [3:0]        oe_ff;
  logic              irq_ff;
  logic [1:0]        ov_a;
  logic [1:0]        ov_b;
  logic [1:0]        ov_c;
  logic [1:0]        ov_d;

  // ==========================================================
  // input synchronisers
  // pins are asynchronous: the sync adds the one-clock jitter
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
    end else begin
      sync1_ff <= {shutdown_src_n, src_active, data_in};
      sync2_ff <= sync1_ff;
    end
  end

  assign data_s   = sync2_ff[0];
  assign active_s = sync2_ff[1];
  assign src_n_s  = sync2_ff[SYNC_W-1:2];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      data_d_ff <= 1'b0;
    end else begin
      data_d_ff <= data_s;
    end
  end

  assign data_rise = data_s & ~data_d_ff;
  assign data_fall = ~data_s & data_d_ff;

  // ==========================================================
  // Avalon-MM slave: one wait cycle, then the request is taken
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_ff;
  assign wr_fire         = avs_write & ack_ff;
  assign wr_ok           = wr_fire & avs_byteenable[0];
  assign avs_readdata    = rdata_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  always_comb begin
    nxt_rdata = '0;
    case (avs_address)
      OFS_CTRL: begin
        nxt_rdata[CTRL_EN_BIT] = en_ff;
        nxt_rdata[CTRL_LD_BIT] = ld_req_ff;
        nxt_rdata[2:0]         = mode_ff;
      end
      OFS_POL: begin
        nxt_rdata[POL_IN_BIT]  = data_s;
        nxt_rdata[3:0]         = pol_ff;
      end
      OFS_CLK:   nxt_rdata[CLK_SEL_BIT] = clk_sel_ff;
      OFS_RISE:  nxt_rdata[DB_W-1:0]    = rise_buf_ff;
      OFS_FALL:  nxt_rdata[DB_W-1:0]    = fall_buf_ff;
      OFS_SHUT: begin
        nxt_rdata[SHUT_SD_BIT]                  = sd_ff;
        nxt_rdata[SHUT_REN_BIT]                 = ren_ff;
        nxt_rdata[SHUT_LBD_LSB+1:SHUT_LBD_LSB]  = lvl_bd_ff;
        nxt_rdata[SHUT_LAC_LSB+1:SHUT_LAC_LSB]  = lvl_ac_ff;
      end
      OFS_SRCEN: nxt_rdata[NSRC-1:0] = src_en_ff;
      OFS_STATE: begin
        nxt_rdata[STATE_RUN_BIT] = (state_ff == ST_RUN);
        nxt_rdata[STATE_REV_BIT] = dir_ff;
      end
      default:   nxt_rdata = '0;
    endcase
  end

  // read data captured in the wait cycle, stands at the taking edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else if (avs_read & ~ack_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      en_ff      <= 1'b0;
      mode_ff    <= MODE_RST;
      pol_ff     <= POL_RST;
      clk_sel_ff <= 1'b0;
      ren_ff     <= 1'b0;
      lvl_bd_ff  <= LVL_RST;
      lvl_ac_ff  <= LVL_RST;
      src_en_ff  <= '0;
    end else if (wr_ok) begin
      case (avs_address)
        OFS_CTRL: begin
          en_ff   <= avs_writedata[CTRL_EN_BIT];
          mode_ff <= avs_writedata[2:0];
        end
        OFS_POL:   pol_ff     <= avs_writedata[3:0];
        OFS_CLK:   clk_sel_ff <= avs_writedata[CLK_SEL_BIT];
        OFS_SHUT: begin
          ren_ff    <= avs_writedata[SHUT_REN_BIT];
          lvl_bd_ff <= avs_writedata[SHUT_LBD_LSB+1:SHUT_LBD_LSB];
          lvl_ac_ff <= avs_writedata[SHUT_LAC_LSB+1:SHUT_LAC_LSB];
        end
        OFS_SRCEN: src_en_ff <= avs_writedata[NSRC-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      en_d_ff <= 1'b0;
    end else begin
      en_d_ff <= en_ff;
    end
  end

  // ==========================================================
  // dead-band double buffers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rise_buf_ff <= '0;
      fall_buf_ff <= '0;
    end else if (wr_ok && avs_address == OFS_RISE) begin
      rise_buf_ff <= avs_writedata[DB_W-1:0];
    end else if (wr_ok && avs_address == OFS_FALL) begin
      fall_buf_ff <= avs_writedata[DB_W-1:0];
    end
  end

  // load request: arm on first fall, transfer on the next rise
  // a request written together with the enable is not guarded
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ld_req_ff  <= 1'b0;
      ld_fell_ff <= 1'b0;
    end else if (!en_ff) begin
      ld_req_ff  <= 1'b0;
      ld_fell_ff <= 1'b0;
    end else if (ld_fell_ff & data_rise) begin
      ld_req_ff  <= wr_ok && avs_address == OFS_CTRL && avs_writedata[CTRL_LD_BIT];
      ld_fell_ff <= 1'b0;
    end else begin
      if (wr_ok && avs_address == OFS_CTRL && avs_writedata[CTRL_LD_BIT]) begin
        ld_req_ff <= 1'b1;
      end
      if (ld_req_ff & data_fall) begin
        ld_fell_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rise_act_ff <= '0;
      fall_act_ff <= '0;
    end else if (!en_ff || (ld_fell_ff & data_rise)) begin
      rise_act_ff <= rise_buf_ff;
      fall_act_ff <= fall_buf_ff;
    end
  end

  // ==========================================================
  // shutdown status
  assign hw_sd = |(src_en_ff & ~src_n_s);

  always_comb begin
    nxt_sd = sd_ff;
    if (!hw_sd && ren_ff) begin
      nxt_sd = 1'b0;
    end
    if (wr_ok && avs_address == OFS_SHUT && !avs_writedata[SHUT_SD_BIT] && !hw_sd) begin
      nxt_sd = 1'b0;
    end
    // any set wins over a software or auto-restart clear in the same cycle; disabling clears over all
    if (wr_ok && avs_address == OFS_SHUT && avs_writedata[SHUT_SD_BIT]) begin
      nxt_sd = 1'b1;
    end
    if (hw_sd || (en_ff & ~en_d_ff)) begin
      nxt_sd = 1'b1;
    end
    if (!en_ff) begin
      nxt_sd = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sd_ff  <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      sd_ff  <= nxt_sd;
      irq_ff <= nxt_sd & ~sd_ff;
    end
  end

  assign generator_irq_flag = irq_ff;

  // ==========================================================
  // run state: goes from shutdown to run only on a data rising edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= ST_OFF;
    end else begin
      case (state_ff)
        ST_OFF: begin
          if (en_ff) begin
            state_ff <= ST_SHUT;
          end
        end
        ST_SHUT: begin
          if (!en_ff) begin
            state_ff <= ST_OFF;
          end else if (!nxt_sd && !sd_ff && data_rise) begin
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!en_ff) begin
            state_ff <= ST_OFF;
          end else if (nxt_sd) begin
            state_ff <= ST_SHUT;
          end
        end
        default: state_ff <= ST_OFF;
      endcase
    end
  end

  // ==========================================================
  // direction tracking for full bridge
  assign is_half = (mode_ff == MODE_HALF);
  assign is_full = (mode_ff == MODE_FWD) || (mode_ff == MODE_REV);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dir_ff  <= 1'b0;
      pend_ff <= 1'b0;
    end else if (!is_full) begin
      dir_ff  <= mode_ff[0];
      pend_ff <= 1'b0;
    end else if (data_rise && dir_ff != mode_ff[0]) begin
      dir_ff  <= mode_ff[0];
      pend_ff <= 1'b1;
    end else if (rise_done | fall_done) begin
      pend_ff <= 1'b0;
    end
  end

  // ==========================================================
  // dead-band counters
  always_comb begin
    if (is_half) begin
      rise_run = data_s;
      fall_run = ~data_s;
    end else begin
      rise_run = is_full & pend_ff & dir_ff & data_s;
      fall_run = is_full & pend_ff & ~dir_ff & data_s;
    end
  end

  // count restarts when the input reverses, so no short pulse
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rise_cnt_ff <= '0;
      fall_cnt_ff <= '0;
    end else begin
      rise_cnt_ff <= band_next(rise_cnt_ff, rise_run, rise_act_ff);
      fall_cnt_ff <= band_next(fall_cnt_ff, fall_run, fall_act_ff);
    end
  end

  assign rise_done = rise_run & (rise_cnt_ff == rise_act_ff);
  assign fall_done = fall_run & (fall_cnt_ff == fall_act_ff);

  // ==========================================================
  // output drive
  always_comb begin
    act = 4'h0;
    if (is_half) begin
      act[0] = rise_done;
      act[1] = fall_done;
    end else if (is_full && !dir_ff) begin
      act[0] = 1'b1;
      act[3] = data_s & (~pend_ff | fall_done);
    end else if (is_full) begin
      act[2] = 1'b1;
      act[1] = data_s & (~pend_ff | rise_done);
    end
  end

  assign ov_a = ovr_decode(lvl_ac_ff, pol_ff[0]);
  assign ov_b = ovr_decode(lvl_bd_ff, pol_ff[1]);
  assign ov_c = ovr_decode(lvl_ac_ff, pol_ff[2]);
  assign ov_d = ovr_decode(lvl_bd_ff, pol_ff[3]);

  always_comb begin
    nxt_lvl = act ^ pol_ff;
    nxt_oe  = 4'hf;
    if (!en_ff) begin
      nxt_lvl = 4'h0;
      nxt_oe  = 4'h0;
    end else if (nxt_sd || state_ff != ST_RUN) begin
      // overrides ignore polarity except the inactive code
      nxt_oe  = {ov_d[1], ov_c[1], ov_b[1], ov_a[1]};
      nxt_lvl = {ov_d[0], ov_c[0], ov_b[0], ov_a[0]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lvl_ff <= 4'h0;
      oe_ff  <= 4'h0;
    end else begin
      lvl_ff <= nxt_lvl;
      oe_ff  <= nxt_oe;
    end
  end

  assign out_lvl = gen_out_s'(lvl_ff);
  assign out_oe  = gen_out_s'(oe_ff);

  // ==========================================================
  // sleep: generator keeps running on ref_clk; ask to keep it alive
  assign osc_keep_on = sleep_mode & en_ff & active_s & clk_sel_ff;

endmodule // complementary_generator

/* File: sim/switch_fault_model.sv */
// far-side model: fault sources into the generator and the switch pins it drives
`timescale 1ns/100ps

module switch_fault_model
  import cwg_pkg::*;
#(
  parameter int NSRC = SRC_COUNT
) (
  input  wire logic            ref_clk,
  input  wire logic [NSRC-1:0] fault_req,
  input  wire gen_out_s        out_lvl,
  input  wire gen_out_s        out_oe,
  output logic [NSRC-1:0]      shutdown_src_n,
  output logic [3:0]           pin
);
  // ==========
  // faults are levels, raised just after an edge, low while active
  initial shutdown_src_n = '1;
  always @(posedge ref_clk) shutdown_src_n <= ~fault_req;

  // pull-downs hold an undriven switch input off
  assign pin = out_oe & out_lvl;
endmodule // switch_fault_model

/* File: sim/complementary_generator_sva.sv */
// port assertions of the complementary generator and their bind
`timescale 1ns/100ps

module complementary_generator_chk
  import cwg_pkg::*;
#(
  parameter int DB_W = DB_WIDTH,
  parameter int NSRC = SRC_COUNT
) (
  input wire logic            ref_clk,
  input wire logic            rst_n,
  input wire logic [4:0]      avs_address,
  input wire logic            avs_read,
  input wire logic            avs_write,
  input wire logic [31:0]     avs_writedata,
  input wire logic [3:0]      avs_byteenable,
  input wire logic            avs_waitrequest,
  input wire logic [NSRC-1:0] shutdown_src_n,
  input wire logic            sleep_mode,
  input wire gen_out_s        out_lvl,
  input wire gen_out_s        out_oe,
  input wire logic            generator_irq_flag,
  input wire logic            osc_keep_on
);
  // ==========
  // shadow of committed writes; settings are not visible at the ports
  logic            en_ff;
  logic [NSRC-1:0] srcen_ff;
  logic [1:0]      bd_ff;
  logic [1:0]      ac_ff;
  logic            take;
  logic            hit;
  assign take = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign hit  = en_ff && |(srcen_ff & ~shutdown_src_n);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      en_ff    <= 1'b0;
      srcen_ff <= '0;
      bd_ff    <= 2'h0;
      ac_ff    <= 2'h0;
    end else if (take) begin
      if (avs_address == OFS_CTRL) en_ff <= avs_writedata[CTRL_EN_BIT];
      if (avs_address == OFS_SRCEN) srcen_ff <= avs_writedata[NSRC-1:0];
      if (avs_address == OFS_SHUT) begin
        bd_ff <= avs_writedata[SHUT_LBD_LSB+:2];
        ac_ff <= avs_writedata[SHUT_LAC_LSB+:2];
      end
    end
  end

  // code 00 depends on polarity, left to the bench
  function automatic logic lvl_ok(input logic [1:0] c, input logic oe, input logic lv);
    if (c == LVL_FLOAT) return !oe;
    return c == LVL_INACT || (oe && lv == (c == LVL_HIGH));
  endfunction

  // ==========
  // assertions
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_fault;
    hit [*6];
  endsequence
  sequence s_enable;
    take && avs_address == OFS_CTRL && avs_writedata[CTRL_EN_BIT] && !en_ff;
  endsequence

  property p_ovr_bd;
    s_fault |-> lvl_ok(bd_ff, out_oe.b, out_lvl.b) && lvl_ok(bd_ff, out_oe.d, out_lvl.d);
  endproperty
  a_ovr_bd: assert property (p_ovr_bd) else $error("b/d off override level in fault");
  property p_ovr_ac;
    s_fault |-> lvl_ok(ac_ff, out_oe.a, out_lvl.a) && lvl_ok(ac_ff, out_oe.c, out_lvl.c);
  endproperty
  a_ovr_ac: assert property (p_ovr_ac) else $error("a/c off override level in fault");
  property p_irq_en;
    s_enable |-> ##[1:4] generator_irq_flag;
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("no flag after enable");
  property p_irq_pulse;
    generator_irq_flag |=> !generator_irq_flag;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("flag longer than a pulse");
  property p_osc;
    osc_keep_on |-> sleep_mode && en_ff;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator kept on wrongly");
  property p_dis_oe;
    !en_ff [*3] |-> 4'(out_oe) == 4'h0;
  endproperty
  a_dis_oe: assert property (p_dis_oe) else $error("disabled block drives pins");
  property p_wait_first;
    (avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("new request not held off");
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("more than one wait cycle");
endmodule // complementary_generator_chk

bind complementary_generator complementary_generator_chk #(.DB_W(DB_W), .NSRC(NSRC)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .shutdown_src_n(shutdown_src_n), .sleep_mode(sleep_mode),
  .out_lvl(out_lvl), .out_oe(out_oe), .generator_irq_flag(generator_irq_flag), .osc_keep_on(osc_keep_on));

/* File: sim/tb_complementary_generator.sv */
// self-checking bench of the complementary generator
`timescale 1ns/100ps

module tb_complementary_generator;
  import cwg_pkg::*;

  // ==========
  // stimulus and wiring
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        data_in = 1'b0;
  logic [3:0]  shutdown_src_n;
  logic        src_active = 1'b0;
  logic        sleep_mode = 1'b0;
  logic [3:0]  fault_req = 4'h0;
  logic [3:0]  pin;
  gen_out_s    out_lvl;
  gen_out_s    out_oe;
  logic        generator_irq_flag;
  logic        osc_keep_on;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          irqs = 0;

  always #12.5 ref_clk = ~ref_clk;

  complementary_generator #(.DB_W(DB_WIDTH), .NSRC(SRC_COUNT)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .data_in(data_in),
    .shutdown_src_n(shutdown_src_n), .src_active(src_active), .sleep_mode(sleep_mode),
    .out_lvl(out_lvl), .out_oe(out_oe), .generator_irq_flag(generator_irq_flag), .osc_keep_on(osc_keep_on));
  switch_fault_model #(.NSRC(SRC_COUNT)) u_far (
    .ref_clk(ref_clk), .fault_req(fault_req), .out_lvl(out_lvl), .out_oe(out_oe),
    .shutdown_src_n(shutdown_src_n), .pin(pin));

  // ==========
  // common tasks
  task automatic test_done();
    $display("Compared %0d, mismatched %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (generator_irq_flag === 1'b1) irqs++;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // request stays up until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'h1, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, 4'h1, q);
    check(q, exp);
  endtask

  // moves data_in, times the turn-on of one pin; an overlap of a and b fails it
  task automatic lag(input logic v, input int idx, input int n);
    int k;
    k = 0;
    data_in <= v;
    do begin
      @(posedge ref_clk);
      k++;
      if (pin[0] & pin[1]) k = 999;
    end while ((pin[idx] & ~pin[idx ^ 2]) !== 1'b1 && k < 300);
    check(32'(k >= n + 3 && k <= n + 5), 32'h1);
  endtask

  // b/d follow code c, a/c follow 3-c; polarity left at normal
  task automatic ovr(input logic [1:0] c);
    logic [3:0] eo;
    logic [3:0] el;
    logic [1:0] k;
    for (int i = 0; i < 4; i++) begin
      k = i[0] ? c : 2'h3 - c;
      eo[i] = (k != LVL_FLOAT);
      el[i] = (k == LVL_HIGH);
    end
    check(32'({out_oe, out_lvl}), 32'({eo, el}));
  endtask

  task automatic start(input logic [7:0] n, input logic [7:0] m, input logic [7:0] sh);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_RISE, n);
    wr(OFS_FALL, m);
    wr(OFS_SHUT, sh);
    wr(OFS_CTRL, {1'b1, 4'h0, MODE_HALF});
    if (!sh[SHUT_REN_BIT]) rd(OFS_SHUT, {24'h0, sh | 8'h80});
    wr(OFS_SHUT, sh);
    data_in <= 1'b1;
    tick(80);
    data_in <= 1'b0;
    tick(80);
  endtask

  // ==========
  // scenarios
  task automatic t_regs();
    logic [31:0] q;
    check(32'(out_oe), 32'h0);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_SHUT, 32'h0);
    wr(5'h03, 8'hff);
    rd(5'h03, 32'h0);
    bus(1'b1, OFS_RISE, 8'h2a, 4'h0, q);
    rd(OFS_RISE, 32'h0);
    wr(OFS_RISE, 8'hff);
    rd(OFS_RISE, 32'h3f);
  endtask

  task automatic t_half();
    int rn[3] = '{0, 7, 63};
    int fn[3] = '{63, 0, 7};
    for (int i = 0; i < 3; i++) begin
      start(8'(rn[i]), 8'(fn[i]), 8'h40);
      lag(1'b1, 0, rn[i]);
      tick(80);
      lag(1'b0, 1, fn[i]);
      tick(80);
    end
  endtask

  task automatic t_load();
    logic seen;
    seen = 1'b0;
    start(8'd5, 8'd3, 8'h40);
    data_in <= 1'b1;
    tick(2);
    data_in <= 1'b0;
    repeat (20) begin
      @(posedge ref_clk);
      seen |= pin[0];
    end
    check(32'(seen), 32'h0);
    wr(OFS_RISE, 8'd10);
    wr(OFS_CTRL, {2'h3, 3'h0, MODE_HALF});
    lag(1'b1, 0, 5);
    tick(20);
    lag(1'b0, 1, 3);
    tick(20);
    lag(1'b1, 0, 10);
    rd(OFS_CTRL, {24'h0, 1'b1, 4'h0, MODE_HALF});
  endtask

  task automatic t_shut();
    logic [7:0] sh;
    int         i0;
    for (int c = 0; c < 4; c++) begin
      sh = {2'h0, 2'(c), 2'(3 - c), 2'h0};
      start(8'd0, 8'd0, sh);
      i0 = irqs;
      wr(OFS_SHUT, sh | 8'h80);
      data_in <= 1'b1;
      tick(20);
      ovr(2'(c));
      check(32'(irqs), 32'(i0 + 1));
      wr(OFS_SHUT, sh);
      data_in <= 1'b0;
      tick(5);
      ovr(2'(c));
      lag(1'b1, 0, 0);
      data_in <= 1'b0;
      wr(OFS_SRCEN, 8'h04);
      fault_req <= 4'h2;
      tick(8);
      rd(OFS_SHUT, {24'h0, sh});
      fault_req <= 4'h4;
      tick(8);
      ovr(2'(c));
      check(32'(irqs), 32'(i0 + 2));
      wr(OFS_SHUT, sh);
      rd(OFS_SHUT, {24'h0, sh | 8'h80});
      if (c[0]) wr(OFS_SRCEN, 8'h00);
      else fault_req <= 4'h0;
      tick(4);
      wr(OFS_SHUT, sh);
      rd(OFS_SHUT, {24'h0, sh});
      lag(1'b1, 0, 0);
      fault_req <= 4'h0;
      data_in <= 1'b0;
      wr(OFS_SRCEN, 8'h04);
      wr(OFS_SHUT, sh | 8'h40);
      fault_req <= 4'h4;
      tick(8);
      ovr(2'(c));
      fault_req <= 4'h0;
      tick(6);
      rd(OFS_SHUT, {24'h0, sh | 8'h40});
      lag(1'b1, 0, 0);
    end
  endtask

  task automatic t_sleep();
    wr(OFS_CLK, 8'h01);
    sleep_mode <= 1'b1;
    src_active <= 1'b1;
    tick(5);
    check(32'(osc_keep_on), 32'h1);
    lag(1'b0, 1, 0);
    wr(OFS_CLK, 8'h00);
    check(32'(osc_keep_on), 32'h0);
    sleep_mode <= 1'b0;
  endtask

  task automatic t_full();
    start(8'd9, 8'd4, 8'h40);
    wr(OFS_CTRL, {1'b1, 4'h0, MODE_REV});
    lag(1'b1, 1, 9);
    data_in <= 1'b0;
    wr(OFS_CTRL, {1'b1, 4'h0, MODE_FWD});
    lag(1'b1, 3, 4);
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(1);
    t_regs();
    t_half();
    t_load();
    t_shut();
    t_sleep();
    t_full();
    test_done();
  end
endmodule // tb_complementary_generator
